// *** inc/adcm_pkg.sv ***
// package: register map, field layout and mux encodings for the adc config block
// Summary of operation
// - buffer code n gives 2**n words per input
// - length register bits 15..3 read zero, ignore writes
// - sample A pos select: 1 picks AN3-5, 0 AN0-2
// - sample B pos select follows same pattern
// - twelve bit mode hides ch1-3 selects, reads zero
package adcm_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// register offsets (word index)
	localparam logic [ADDR_W-1:0] OFS_BUF_LEN = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CH123_SEL = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_MODE = 4'h2;
	// reset values
	localparam logic [DATA_W-1:0] RST_BUF_LEN = 16'h0000;
	localparam logic [DATA_W-1:0] RST_CH123_SEL = 16'h0000;
	localparam logic [DATA_W-1:0] RST_MODE = 16'h0000;
	// field positions
	localparam int BUF_WORDS_LSB = 0;
	localparam int BUF_WORDS_W = 3;
	localparam int POS_SEL_A_BIT = 0;
	localparam int NEG_SEL_A_LSB = 1;
	localparam int POS_SEL_B_BIT = 8;
	localparam int NEG_SEL_B_LSB = 9;
	localparam int MODE_12B_BIT = 0;
	localparam int AN_W = 5;
	// analog input numbers feeding channels 1..3
	localparam logic [AN_W-1:0] AN_POS_LO = 5'h00;
	localparam logic [AN_W-1:0] AN_POS_HI = 5'h03;
	localparam logic [AN_W-1:0] AN_NEG_LO = 5'h06;
	localparam logic [AN_W-1:0] AN_NEG_HI = 5'h09;
	localparam logic [1:0] NEG_CODE_LO = 2'h2;
	// one sample set-up for channels 1..3
	typedef struct packed {
		logic [1:0] neg_sel;
		logic pos_sel;
	} adcm_samp_cfg_s;
	// routed inputs of one channel
	typedef struct packed {
		logic [AN_W-1:0] pos_an;
		logic neg_is_vref;
		logic [AN_W-1:0] neg_an;
	} adcm_route_s;
endpackage

// *** hw/adcm_route.sv ***
// module: decodes one sample set-up into channel 1..3 input routing
module adcm_route
	import adcm_pkg::*;
(
	// set-up in
	input wire adcm_pkg::adcm_samp_cfg_s i_cfg,
	input wire logic i_en,
	// routing out, channel 1 at index 0
	output adcm_pkg::adcm_route_s o_route [3]
);
	// per channel offset added to the base input
	for (genvar c = 0; c < 3; c++) begin : g_ch
		always_comb begin
			o_route[c].pos_an = (i_en && i_cfg.pos_sel) ? AN_POS_HI + AN_W'(c)
				: AN_POS_LO + AN_W'(c);
			o_route[c].neg_is_vref = !i_en || !i_cfg.neg_sel[1];
			if (!i_en || !i_cfg.neg_sel[1]) begin
				o_route[c].neg_an = '0;
			end else if (i_cfg.neg_sel == NEG_CODE_LO) begin
				o_route[c].neg_an = AN_NEG_LO + AN_W'(c);
			end else begin
				o_route[c].neg_an = AN_NEG_HI + AN_W'(c);
			end
		end
	end
endmodule

// *** hw/adcm_cfg.sv ***
// module: adc dma buffer length and channel 1..3 mux select registers
//
// Implementation choices: the address-and-strobe port and the register offsets.
module adcm_cfg (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// register port
	input wire logic [adcm_pkg::ADDR_W-1:0] i_addr,
	input wire logic [adcm_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [adcm_pkg::DATA_W-1:0] o_rdata,
	// configuration out
	output logic o_twelve_bit_mode,
	output logic [adcm_pkg::BUF_WORDS_W-1:0] o_buffer_words_per_input,
	output logic [7:0] o_buffer_words,
	output adcm_pkg::adcm_route_s o_route_a [3],
	output adcm_pkg::adcm_route_s o_route_b [3]
);
	import adcm_pkg::*;

	logic [BUF_WORDS_W-1:0] buf_code_r, buf_code_nxt;
	adcm_samp_cfg_s cfg_a_r, cfg_a_nxt, cfg_b_r, cfg_b_nxt;
	logic mode_r, mode_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;

	// register writes; only implemented bits are stored
	always_comb begin
		buf_code_nxt = buf_code_r;
		cfg_a_nxt = cfg_a_r;
		cfg_b_nxt = cfg_b_r;
		mode_nxt = mode_r;
		if (i_wr) begin
			if (i_addr == OFS_BUF_LEN) begin
				buf_code_nxt = i_wdata[BUF_WORDS_LSB +: BUF_WORDS_W];
			end else if (i_addr == OFS_CH123_SEL) begin
				if (!mode_r) begin
					cfg_a_nxt.pos_sel = i_wdata[POS_SEL_A_BIT];
					cfg_a_nxt.neg_sel = i_wdata[NEG_SEL_A_LSB +: 2];
					cfg_b_nxt.pos_sel = i_wdata[POS_SEL_B_BIT];
					cfg_b_nxt.neg_sel = i_wdata[NEG_SEL_B_LSB +: 2];
				end
			end else if (i_addr == OFS_MODE) begin
				mode_nxt = i_wdata[MODE_12B_BIT];
			end
		end
	end

	// read mux; unmapped and unimplemented bits return zero
	always_comb begin
		rdata_nxt = '0;
		if (i_rd) begin
			if (i_addr == OFS_BUF_LEN) begin
				rdata_nxt[BUF_WORDS_LSB +: BUF_WORDS_W] = buf_code_r;
			end else if (i_addr == OFS_CH123_SEL) begin
				if (!mode_r) begin
					rdata_nxt[POS_SEL_A_BIT] = cfg_a_r.pos_sel;
					rdata_nxt[NEG_SEL_A_LSB +: 2] = cfg_a_r.neg_sel;
					rdata_nxt[POS_SEL_B_BIT] = cfg_b_r.pos_sel;
					rdata_nxt[NEG_SEL_B_LSB +: 2] = cfg_b_r.neg_sel;
				end
			end else if (i_addr == OFS_MODE) begin
				rdata_nxt[MODE_12B_BIT] = mode_r;
			end
		end
	end

	// state registers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			buf_code_r <= RST_BUF_LEN[BUF_WORDS_LSB +: BUF_WORDS_W];
			cfg_a_r <= RST_CH123_SEL[POS_SEL_A_BIT +: 3];
			cfg_b_r <= RST_CH123_SEL[POS_SEL_B_BIT +: 3];
			mode_r <= RST_MODE[MODE_12B_BIT];
			rdata_r <= '0;
		end else begin
			buf_code_r <= buf_code_nxt;
			cfg_a_r <= cfg_a_nxt;
			cfg_b_r <= cfg_b_nxt;
			mode_r <= mode_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// outputs; stored selects survive 12-bit mode but are masked from routing
	assign o_rdata = rdata_r;
	assign o_twelve_bit_mode = mode_r;
	assign o_buffer_words_per_input = buf_code_r;
	assign o_buffer_words = 8'h01 << buf_code_r;

	adcm_route u_route_a (
		.i_cfg(cfg_a_r),
		.i_en(!mode_r),
		.o_route(o_route_a)
	);
	adcm_route u_route_b (
		.i_cfg(cfg_b_r),
		.i_en(!mode_r),
		.o_route(o_route_b)
	);
endmodule

// *** sim/adcm_sh_model.sv ***
// partner: channel 1..3 sample/hold side, reports the channel 1 positive input
module adcm_sh_model (
	// routing from the block
	input wire adcm_pkg::adcm_route_s i_route [3],
	// what channel 1 samples
	output logic [4:0] o_ch1_pos
);
	timeunit 1ns;
	timeprecision 1ns;
	// channel 1 samples whatever is routed, with no delay
	assign o_ch1_pos = i_route[0].pos_an;
endmodule

// *** sim/adcm_chk_assertions.sv ***
// checker: register port and routing properties
module adcm_chk import adcm_pkg::*; (
	// watched ports
	input wire logic i_clk, i_srst, i_wr, i_rd, o_twelve_bit_mode,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata, o_rdata,
	input wire logic [7:0] o_buffer_words,
	input wire adcm_route_s o_route_a [3], o_route_b [3]
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// select writes only land outside twelve bit mode
	wire s = i_wr && i_addr == 4'h1 && !o_twelve_bit_mode;
	len_decode_a: assert property (i_wr && i_addr == 4'h0 |=>
		o_buffer_words == 8'h1 << $past(i_wdata[2:0])) else $error("len");
	len_read_a: assert property (i_rd && i_addr == 4'h0 |=> o_rdata[15:3] == 13'h0) else $error("rd");
	pos_a_a: assert property (s |=> o_route_a[2].pos_an == ($past(i_wdata[0]) ? 5'h05 : 5'h02)) else $error("pa");
	pos_b_a: assert property (s |=> o_route_b[1].pos_an == ($past(i_wdata[8]) ? 5'h04 : 5'h01)) else $error("pb");
	mode_hide_a: assert property (i_rd && i_addr == 4'h1 && o_twelve_bit_mode |=> o_rdata == 16'h0) else $error("md");
	neg_a_a: assert property (s |=> o_route_a[0].neg_is_vref == !$past(i_wdata[2])) else $error("na");
endmodule
bind adcm_cfg adcm_chk adcm_chk_inst (.*);

// *** sim/testbench.sv ***
// testbench: random and corner register traffic with route checks
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import adcm_pkg::*;
	logic i_clk = 1'h0, i_srst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, md;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0, o_rdata, d, v;
	logic [7:0] bw;
	logic [4:0] c1;
	logic [2:0] bpi;
	adcm_route_s ra [3], rb [3];
	int err_count = 0, checks = 0, seed = 98, m, k;
	always #20 i_clk = ~i_clk;
	adcm_cfg adcm_cfg_inst (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_twelve_bit_mode(md), .o_buffer_words_per_input(bpi),
		.o_buffer_words(bw), .o_route_a(ra), .o_route_b(rb));
	adcm_sh_model adcm_sh_model_inst (.i_route(ra), .o_ch1_pos(c1));
	task automatic chk(input logic [15:0] s, e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask
	// one strobe cycle; read data is taken in the cycle after it
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] x);
		@(posedge i_clk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= x;
		@(posedge i_clk);
		i_wr <= 1'h0;
		i_rd <= 1'h0;
		#1 d = o_rdata;
	endtask
	// expected route word: pad, positive input, vref flag, negative input
	function automatic logic [15:0] rt(input logic p, input logic [1:0] n, input int k);
		return {5'h0, p ? 5'(3 + k) : 5'(k), !n[1], n[1] ? 5'((n[0] ? 9 : 6) + k) : 5'h0};
	endfunction
	task automatic give_verdict;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog, well beyond the roughly 576 cycles of traffic
	initial begin
		#200000;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_srst <= 1'h0;
		chk({8'h0, bw}, 16'h1);
		for (m = 0; m < 40; m++) begin
			v = m < 2 ? {16{m[0]}} : 16'($random(seed));
			acc(1, 4'h2, {15'h0, v[15]});
			acc(1, 4'h1, v);
			acc(0, 4'h1, v);
			chk(d, v[15] ? 16'h0 : v & 16'h0707);
			chk({11'h0, c1}, {14'h0, {2{!v[15] && v[0]}}});
			for (k = 0; k < 3; k++) begin
				chk({5'h0, ra[k]}, v[15] ? rt(0, 0, k) : rt(v[0], v[2:1], k));
				chk({5'h0, rb[k]}, v[15] ? rt(0, 0, k) : rt(v[8], v[10:9], k));
			end
			acc(0, 4'h2, v);
			chk(d, {15'h0, v[15]});
			chk({15'h0, md}, {15'h0, v[15]});
			acc(1, 4'h0, v);
			acc(0, 4'h0, v);
			chk({13'h0, bpi}, {13'h0, v[2:0]});
			chk({8'h0, bw}, 16'h1 << v[2:0]);
			chk(d, {13'h0, v[2:0]});
			acc(0, 4'hf, v);
			chk(d, 16'h0);
			$display("test %0d done", m);
		end
		give_verdict();
	end
endmodule
